// ---- src/lieg_exec.sv ----
// instruction execution group: data memory, flags, counter, timer, scan pacing
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "lieg_defines.svh"
module lieg_exec #(
  parameter int TENTH_MS_CYCLES = `LIEG_TENTH_MS_CYCLES,
  parameter int HUNDREDTH_S_CYCLES = `LIEG_HUNDREDTH_S_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire lieg_pkg::lieg_bus_req_t bus,
  output logic [31:0] rdata,
  input wire logic scan_end,
  output logic next_scan,
  output logic scan_wait
);
  import lieg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic in_rng(input int i, input logic [5:0] st, input logic [5:0] e);
    in_rng = (i >= int'(st)) && (i <= int'(e));
  endfunction

  // top half of the index space models the read-only data memory words
  function automatic logic is_ro(input logic [5:0] idx);
    is_ro = idx[5];
  endfunction

  function automatic logic range_ok(input logic [5:0] st, input logic [5:0] e);
    range_ok = (st <= e) && (st[5] == e[5]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] mem_reg [`LIEG_MEM_WORDS];
  logic [15:0] mem_next [`LIEG_MEM_WORDS];
  lieg_cmd_t cmd_reg;
  logic gr_reg, eq_reg, lt_reg, latch_reg, rise_reg, fall_reg, carry_reg;
  logic err_range_reg, err_ro_reg;
  logic pulse_prev_reg, up_prev_reg, down_prev_reg, rise_prev_reg, fall_prev_reg;
  logic [13:0] cnt_sv_reg, cnt_pv_reg, tim_sv_reg, tim_pv_reg, scan_min_reg;
  logic tim_in_reg, tim_done_reg;
  logic [31:0] tim_pre_reg, scan_pre_reg;
  logic [13:0] scan_elapsed_reg;
  lieg_scan_t scan_reg;
  logic [31:0] rdata_reg;
  logic next_scan_reg;

  lieg_cmd_t cmd;
  logic exec, bad_range, bad_ro;
  logic [6:0] blk_a_end, blk_b_end;
  logic [5:0] rws_z;
  logic rws_found;
  logic [15:0] rws_ctl;

  assign cmd = lieg_cmd_t'(bus.wdata);
  assign exec = bus.wr && (bus.addr == `LIEG_ADDR_CMD);
  assign blk_a_end = {1'b0, cmd.opa} + 7'h0f;
  assign blk_b_end = {1'b0, cmd.opb} + 7'h0f;
  assign rws_ctl = mem_reg[cmd.opc];

  ////////////////////////////////////////////////////////////////////////
  // operand checks; a refused command leaves memory untouched
  always_comb
  begin
    bad_range = 1'b0;
    bad_ro = 1'b0;
    case (cmd.op)
      OP_BIT_SHIFT, OP_WORD_SHIFT, OP_REV_SHIFT:
      begin
        bad_range = !range_ok(cmd.opa, cmd.opb);
        bad_ro = is_ro(cmd.opa) || is_ro(cmd.opb);
      end
      OP_BLOCK_CMP:
      begin
        bad_range = blk_a_end[6] || blk_b_end[6] || (cmd.opa[5] != blk_a_end[5]) || (cmd.opb[5] != blk_b_end[5]);
        bad_ro = is_ro(cmd.opc);
      end
      OP_COPY: bad_ro = is_ro(cmd.opb);
      default: ;
    endcase
  end

  // find the zero word that swaps with its neighbour this execution
  always_comb
  begin
    rws_z = 6'h00;
    rws_found = 1'b0;
    for (int i = 0; i < `LIEG_MEM_WORDS; i++)
    begin
      if (!rws_found && mem_reg[i] == 16'h0000)
      begin
        if (!rws_ctl[`LIEG_RWS_DIR_BIT] && i > int'(cmd.opa) && i <= int'(cmd.opb) && mem_reg[i - 1] != 16'h0000)
        begin
          rws_z = 6'(i);
          rws_found = 1'b1;
        end
        else if (rws_ctl[`LIEG_RWS_DIR_BIT] && i >= int'(cmd.opa) && i < int'(cmd.opb)
                 && mem_reg[i + 1] != 16'h0000)
        begin
          rws_z = 6'(i);
          rws_found = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data memory next values; software loads any word, instructions obey read-only area
  always_comb
  begin
    for (int i = 0; i < `LIEG_MEM_WORDS; i++)
      mem_next[i] = mem_reg[i];
    if (bus.wr && bus.addr >= `LIEG_ADDR_MEM_BASE && bus.addr < `LIEG_ADDR_MEM_END)
      mem_next[bus.addr[7:2]] = bus.wdata[15:0];
    if (exec && !bad_range && !bad_ro)
    begin
      case (cmd.op)
        OP_BIT_SHIFT:
        begin
          for (int i = 0; i < `LIEG_MEM_WORDS; i++)
          begin
            if (in_rng(i, cmd.opa, cmd.opb))
            begin
              if (cmd.in2)
                mem_next[i] = 16'h0000;
              else if (cmd.in1 && !pulse_prev_reg)
                mem_next[i] = {mem_reg[i][14:0], (i == int'(cmd.opa)) ? cmd.in0 : mem_reg[i - 1][15]};
            end
          end
        end
        OP_WORD_SHIFT:
        begin
          for (int i = 0; i < `LIEG_MEM_WORDS; i++)
          begin
            if (in_rng(i, cmd.opa, cmd.opb))
              mem_next[i] = (i == int'(cmd.opa)) ? 16'h0000 : mem_reg[i - 1];
          end
        end
        OP_REV_SHIFT:
        begin
          if (rws_ctl[`LIEG_RWS_EN_BIT] && rws_ctl[`LIEG_RWS_CLR_BIT])
          begin
            for (int i = 0; i < `LIEG_MEM_WORDS; i++)
              if (in_rng(i, cmd.opa, cmd.opb))
                mem_next[i] = 16'h0000;
          end
          else if (rws_ctl[`LIEG_RWS_EN_BIT] && rws_found)
          begin
            if (!rws_ctl[`LIEG_RWS_DIR_BIT])
            begin
              mem_next[rws_z] = mem_reg[rws_z - 6'h01];
              mem_next[rws_z - 6'h01] = 16'h0000;
            end
            else
            begin
              mem_next[rws_z] = mem_reg[rws_z + 6'h01];
              mem_next[rws_z + 6'h01] = 16'h0000;
            end
          end
        end
        OP_BLOCK_CMP:
        begin
          for (int k = 0; k < `LIEG_BLOCK_WORDS; k++)
            mem_next[cmd.opc][k] = mem_reg[cmd.opa + 6'(k)] != mem_reg[cmd.opb + 6'(k)];
        end
        OP_COPY: mem_next[cmd.opb] = mem_reg[cmd.opa];
        default: ;
      endcase
    end
  end

  // memory storage
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < `LIEG_MEM_WORDS; i++)
      mem_reg[i] <= rst ? 16'h0000 : mem_next[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // last command, error flags and per-instruction input history
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_reg <= '0;
      err_range_reg <= 1'b0;
      err_ro_reg <= 1'b0;
      pulse_prev_reg <= 1'b0;
    end
    else if (exec)
    begin
      cmd_reg <= cmd;
      err_range_reg <= bad_range;
      err_ro_reg <= bad_ro;
      if (cmd.op == OP_BIT_SHIFT && !bad_range && !bad_ro)
        pulse_prev_reg <= cmd.in1; // edge memory for the shift pulse
    end
  end

  // compare flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gr_reg <= 1'b0;
      eq_reg <= 1'b0;
      lt_reg <= 1'b0;
    end
    else if (exec && cmd.op == OP_WORD_CMP)
    begin
      gr_reg <= mem_reg[cmd.opa] > mem_reg[cmd.opb];
      eq_reg <= mem_reg[cmd.opa] == mem_reg[cmd.opb];
      lt_reg <= mem_reg[cmd.opa] < mem_reg[cmd.opb];
    end
  end

  // latch and edge bits; one execution per scan so one-execution pulse equals one scan
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      latch_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      rise_prev_reg <= 1'b0;
      fall_prev_reg <= 1'b0;
    end
    else if (exec)
    begin
      if (cmd.op == OP_LATCH)
        latch_reg <= !cmd.in1 && (cmd.in0 || latch_reg); // reset dominates
      if (cmd.op == OP_RISE)
      begin
        rise_reg <= cmd.in0 && !rise_prev_reg;
        rise_prev_reg <= cmd.in0;
      end
      if (cmd.op == OP_FALL)
      begin
        fall_reg <= !cmd.in0 && fall_prev_reg;
        fall_prev_reg <= cmd.in0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reversible counter; wraps at set value and at zero, flagging carry
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_pv_reg <= 14'h0000;
      carry_reg <= 1'b0;
      up_prev_reg <= 1'b0;
      down_prev_reg <= 1'b0;
    end
    else if (exec && cmd.op == OP_COUNTER)
    begin
      up_prev_reg <= cmd.in0;
      down_prev_reg <= cmd.in1;
      if (cmd.in2)
      begin
        cnt_pv_reg <= 14'h0000;
        carry_reg <= 1'b0;
      end
      else if (cmd.in0 && !up_prev_reg && !(cmd.in1 && !down_prev_reg))
      begin
        carry_reg <= cnt_pv_reg >= cnt_sv_reg;
        cnt_pv_reg <= (cnt_pv_reg >= cnt_sv_reg) ? 14'h0000 : cnt_pv_reg + 14'h0001;
      end
      else if (cmd.in1 && !down_prev_reg && !(cmd.in0 && !up_prev_reg))
      begin
        carry_reg <= cnt_pv_reg == 14'h0000;
        cnt_pv_reg <= (cnt_pv_reg == 14'h0000) ? cnt_sv_reg : cnt_pv_reg - 14'h0001;
      end
    end
  end

  // set values and minimum scan setting, clamped to their legal ranges
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_sv_reg <= 14'h0000;
      tim_sv_reg <= `LIEG_TIM_SV_MIN;
      scan_min_reg <= 14'h0000;
    end
    else if (bus.wr)
    begin
      if (bus.addr == `LIEG_ADDR_CNT_SV)
        cnt_sv_reg <= (bus.wdata[15:0] > 16'(`LIEG_CNT_SV_MAX)) ? `LIEG_CNT_SV_MAX : bus.wdata[13:0];
      if (bus.addr == `LIEG_ADDR_TIM_SV)
        tim_sv_reg <= (bus.wdata[15:0] < 16'(`LIEG_TIM_SV_MIN)) ? `LIEG_TIM_SV_MIN :
                      (bus.wdata[15:0] > 16'(`LIEG_TIM_SV_MAX)) ? `LIEG_TIM_SV_MAX : bus.wdata[13:0];
      if (bus.addr == `LIEG_ADDR_SCAN_MIN)
        scan_min_reg <= (bus.wdata[15:0] > 16'(`LIEG_SCAN_MIN_MAX)) ? `LIEG_SCAN_MIN_MAX : bus.wdata[13:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fast timer: input off reloads, input on counts down in hundredths
  always_ff @(posedge clk)
  begin
    if (rst)
      tim_in_reg <= 1'b0;
    else if (exec && cmd.op == OP_TIMER)
      tim_in_reg <= cmd.in0;
  end

  always_ff @(posedge clk)
  begin
    if (rst || !tim_in_reg)
    begin
      tim_pv_reg <= rst ? `LIEG_TIM_SV_MIN : tim_sv_reg;
      tim_pre_reg <= 32'h0000_0000;
      tim_done_reg <= 1'b0;
    end
    else if (!tim_done_reg)
    begin
      if (tim_pre_reg == 32'(HUNDREDTH_S_CYCLES - 1))
      begin
        tim_pre_reg <= 32'h0000_0000;
        tim_pv_reg <= tim_pv_reg - 14'h0001;
        tim_done_reg <= tim_pv_reg == 14'h0001;
      end
      else
        tim_pre_reg <= tim_pre_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scan pacing; elapsed time saturates so a long scan never wraps back
  always_ff @(posedge clk)
  begin
    if (rst || next_scan_reg)
    begin
      scan_pre_reg <= 32'h0000_0000;
      scan_elapsed_reg <= 14'h0000;
    end
    else if (scan_pre_reg == 32'(TENTH_MS_CYCLES - 1))
    begin
      scan_pre_reg <= 32'h0000_0000;
      if (scan_elapsed_reg != 14'h3fff)
        scan_elapsed_reg <= scan_elapsed_reg + 14'h0001;
    end
    else
      scan_pre_reg <= scan_pre_reg + 32'h0000_0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scan_reg <= SCAN_RUN;
      next_scan_reg <= 1'b0;
    end
    else
    begin
      next_scan_reg <= 1'b0;
      case (scan_reg)
        SCAN_RUN:
          if (scan_end)
          begin
            if (scan_elapsed_reg >= scan_min_reg)
              next_scan_reg <= 1'b1;
            else
              scan_reg <= SCAN_WAIT;
          end
        SCAN_WAIT:
          if (scan_elapsed_reg >= scan_min_reg)
          begin
            next_scan_reg <= 1'b1;
            scan_reg <= SCAN_RUN;
          end
        default: scan_reg <= SCAN_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (rst || !bus.rd)
      rdata_reg <= 32'h0000_0000;
    else if (bus.addr >= `LIEG_ADDR_MEM_BASE && bus.addr < `LIEG_ADDR_MEM_END)
      rdata_reg <= {16'h0000, mem_reg[bus.addr[7:2]]};
    else
    begin
      case (bus.addr)
        `LIEG_ADDR_CMD: rdata_reg <= 32'(cmd_reg);
        `LIEG_ADDR_STATUS: rdata_reg <= {21'h000000, scan_reg == SCAN_WAIT, err_ro_reg, err_range_reg,
                                          carry_reg, tim_done_reg, fall_reg, rise_reg, latch_reg,
                                          lt_reg, eq_reg, gr_reg};
        `LIEG_ADDR_CNT_SV: rdata_reg <= {18'h00000, cnt_sv_reg};
        `LIEG_ADDR_CNT_PV: rdata_reg <= {18'h00000, cnt_pv_reg};
        `LIEG_ADDR_TIM_SV: rdata_reg <= {18'h00000, tim_sv_reg};
        `LIEG_ADDR_TIM_PV: rdata_reg <= {18'h00000, tim_pv_reg};
        `LIEG_ADDR_SCAN_MIN: rdata_reg <= {18'h00000, scan_min_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign next_scan = next_scan_reg;
  assign scan_wait = scan_reg[1]; // one-hot wait bit, straight from its flop
endmodule // lieg_exec

// ---- src/lieg_defines.svh ----
// constants for the ladder instruction execution group
// Notes on behaviour
// - bit shift forms one bit register over words first..last, with data, pulse, reset
// - latch bit turns on with set, off with reset, else holds
// - counter steps up or down on off-to-on inputs; set value 0 to 9999
// - rising-edge bit is on for exactly one execution after input goes on
// - falling-edge bit is on for exactly one execution after input goes off
// - fast timer is on-delay, counts down; set value 0.02 s to 99.99 s
// - word shift moves range words up one address, zero into first word
// - reversible shift swaps a zero word with its lower or upper neighbour
// - control bit 13 off moves data to higher addresses, on to lower
// - control bit 14 enables reversible shifting
// - control bits 15 and 14 both on clear the whole range
// - minimum scan setting is in tenths of ms, 0 to 999.0 ms
// - a short scan waits until the minimum scan time has elapsed
// - block compare sets result bit for each differing pair of 16 words
// - block compare clears result bit for each equal pair
// - word compare reports greater, equal and less flags
// - word copy moves source word unchanged to destination
// - data memory 1000-1999 is read only to instructions, 0000-0999 read/write
`ifndef LIEG_DEFINES_SVH
`define LIEG_DEFINES_SVH
`define LIEG_ADDR_CMD 12'h000
`define LIEG_ADDR_STATUS 12'h004
`define LIEG_ADDR_CNT_SV 12'h008
`define LIEG_ADDR_CNT_PV 12'h00c
`define LIEG_ADDR_TIM_SV 12'h010
`define LIEG_ADDR_TIM_PV 12'h014
`define LIEG_ADDR_SCAN_MIN 12'h018
`define LIEG_ADDR_MEM_BASE 12'h100
`define LIEG_ADDR_MEM_END 12'h200
`define LIEG_MEM_WORDS 64
`define LIEG_CNT_SV_MAX 14'h270f
`define LIEG_TIM_SV_MIN 14'h0002
`define LIEG_TIM_SV_MAX 14'h270f
`define LIEG_SCAN_MIN_MAX 14'h2706
`define LIEG_RWS_DIR_BIT 13
`define LIEG_RWS_EN_BIT 14
`define LIEG_RWS_CLR_BIT 15
`define LIEG_BLOCK_WORDS 16
`define LIEG_CLK_NS 20
`define LIEG_TENTH_MS_NS 100000
`define LIEG_HUNDREDTH_S_NS 10000000
`define LIEG_TENTH_MS_CYCLES (`LIEG_TENTH_MS_NS / `LIEG_CLK_NS)
`define LIEG_HUNDREDTH_S_CYCLES (`LIEG_HUNDREDTH_S_NS / `LIEG_CLK_NS)
`endif

// ---- src/lieg_pkg.sv ----
// types for the ladder instruction execution group
package lieg_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_BIT_SHIFT = 4'h1, OP_LATCH = 4'h2, OP_COUNTER = 4'h3,
    OP_RISE = 4'h4, OP_FALL = 4'h5, OP_TIMER = 4'h6, OP_WORD_SHIFT = 4'h7,
    OP_REV_SHIFT = 4'h8, OP_BLOCK_CMP = 4'h9, OP_WORD_CMP = 4'ha, OP_COPY = 4'hb
  } lieg_op_t;
  typedef struct packed {
    logic [6:0] unused;
    logic in2;
    logic in1;
    logic in0;
    logic [5:0] opc;
    logic [5:0] opb;
    logic [5:0] opa;
    lieg_op_t op;
  } lieg_cmd_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lieg_bus_req_t;
  typedef enum logic [1:0] {SCAN_RUN = 2'b01, SCAN_WAIT = 2'b10} lieg_scan_t;
endpackage

// ---- bench/lieg_exec_props.sv ----
// assertions on the ports of the instruction execution group
`timescale 1ns/1ps
`include "lieg_defines.svh"
module lieg_exec_props
  import lieg_pkg::*;
#(
  parameter int TENTH_MS_CYCLES = 4,
  parameter int HUNDREDTH_S_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire lieg_pkg::lieg_bus_req_t bus,
  input wire logic [31:0] rdata,
  input wire logic scan_end,
  input wire logic next_scan,
  input wire logic scan_wait
);
  logic [13:0] min_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the minimum scan setting, the wait length depends on it
  always_ff @(posedge clk)
  begin
    if (rst)
      min_reg <= 14'h0000;
    else if (bus.wr && bus.addr == `LIEG_ADDR_SCAN_MIN)
      min_reg <= (bus.wdata[15:0] > 16'(`LIEG_SCAN_MIN_MAX)) ? `LIEG_SCAN_MIN_MAX : bus.wdata[13:0];
  end
  //////////////////////////////////////////////////////////////////////////////
  AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_FLAGS_ONEHOT: assert property ($past(bus.rd && bus.addr == `LIEG_ADDR_STATUS) |-> $onehot0(rdata[2:0]))
    else $error("more than one compare flag set");
  AST_CNT_PV_RANGE: assert property ($past(bus.rd && bus.addr == `LIEG_ADDR_CNT_PV) |-> rdata <= 32'h270f)
    else $error("counter value beyond its range");
  AST_TIM_SV_RANGE: assert property ($past(bus.rd && bus.addr == `LIEG_ADDR_TIM_SV)
    |-> rdata >= 32'h2 && rdata <= 32'h270f)
    else $error("timer setting outside its range");
  AST_TIM_PV_RANGE: assert property ($past(bus.rd && bus.addr == `LIEG_ADDR_TIM_PV) |-> rdata <= 32'h270f)
    else $error("timer value beyond its range");
  AST_NEXT_PULSE: assert property (next_scan |=> !next_scan)
    else $error("next scan pulse longer than one cycle");
  AST_NEXT_CAUSE: assert property (next_scan |-> $past(scan_end) || $past(scan_wait))
    else $error("next scan without a finished scan");
  AST_WAIT_CAUSE: assert property ($rose(scan_wait) |-> $past(scan_end))
    else $error("wait began without scan end");
  AST_ZERO_SETTING: assert property (scan_end && !scan_wait && min_reg == 14'h0 |=> next_scan)
    else $error("zero setting did not start next scan at once");
  AST_WAIT_BOUNDED: assert property ($rose(scan_wait) && int'(min_reg) * TENTH_MS_CYCLES <= 900
    |-> ##[1:1000] next_scan)
    else $error("wait outlasted the minimum scan setting");
  // main scenarios reached
  COV_WAIT_DONE: cover property (next_scan && $past(scan_wait));
  COV_WAIT_START: cover property ($rose(scan_wait));
  COV_EQUAL: cover property ($past(bus.rd && bus.addr == `LIEG_ADDR_STATUS) && rdata[1]);
endmodule // lieg_exec_props
bind lieg_exec lieg_exec_props #(.TENTH_MS_CYCLES(TENTH_MS_CYCLES), .HUNDREDTH_S_CYCLES(HUNDREDTH_S_CYCLES)) props_u (
  .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .scan_end(scan_end), .next_scan(next_scan), .scan_wait(scan_wait));

// ---- bench/lieg_exec_tb.sv ----
// self-checking testbench for the instruction execution group
`timescale 1ns/1ps
`include "lieg_defines.svh"
module testbench;
  import lieg_pkg::*;
  logic clk;
  logic rst;
  lieg_bus_req_t bus;
  logic [31:0] rdata;
  logic scan_end;
  logic next_scan;
  logic scan_wait;
  int errors;
  int comparisons;
  int n;
  logic w;
  logic [31:0] d;
  // short tick counts keep the timer and scan waits brief
  lieg_exec #(.TENTH_MS_CYCLES(4), .HUNDREDTH_S_CYCLES(4)) dut_u (
    .clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .scan_end(scan_end), .next_scan(next_scan), .scan_wait(scan_wait));
  // 50 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // strobe for one cycle, dropped at the next edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask
  task automatic wm(input int i, input logic [15:0] v);
    wr(12'h100 + 12'(4 * i), {16'h0, v});
  endtask
  task automatic cm(input int i, input logic [15:0] e);
    rd(12'h100 + 12'(4 * i));
    chk(d, {16'h0, e});
  endtask
  task automatic sb(input int b, input logic e);
    rd(`LIEG_ADDR_STATUS);
    chk(d[b], e);
  endtask
  task automatic ex(input lieg_op_t op, input logic [5:0] a, input logic [5:0] b, input logic [5:0] c,
    input logic [2:0] in);
    wr(`LIEG_ADDR_CMD, {7'h0, in, c, b, a, op});
  endtask
  // one scan end, then count cycles until the next scan starts
  task automatic scan(output int k, output logic q);
    @(posedge clk);
    scan_end <= 1'b1;
    @(posedge clk);
    scan_end <= 1'b0;
    #1;
    k = 0;
    q = 1'b0;
    while (next_scan !== 1'b1 && k < 40)
    begin
      q = q | scan_wait;
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(`LIEG_ADDR_TIM_PV);
    chk(d, 32'h2);
    wr(12'h020, 32'h5a5a);
    rd(12'h020);
    chk(d, 32'h0);
    wr(`LIEG_ADDR_TIM_SV, 32'h1);
    rd(`LIEG_ADDR_TIM_SV);
    chk(d, 32'h2);
    wr(`LIEG_ADDR_TIM_SV, 32'h2710);
    rd(`LIEG_ADDR_TIM_SV);
    chk(d, 32'h270f);
    wr(`LIEG_ADDR_SCAN_MIN, 32'h2706);
    rd(`LIEG_ADDR_SCAN_MIN);
    chk(d, 32'h2706);
    $display("done registers");
  endtask
  task automatic t_words;
    wm(0, 16'h1234);
    ex(OP_COPY, 0, 1, 0, 0);
    cm(1, 16'h1234);
    rd(`LIEG_ADDR_CMD);
    chk(d, 32'h0000_040b);
    wm(2, 16'h0005);
    ex(OP_WORD_CMP, 0, 2, 0, 0);
    sb(0, 1'b1);
    ex(OP_WORD_CMP, 2, 0, 0, 0);
    sb(2, 1'b1);
    ex(OP_WORD_CMP, 0, 1, 0, 0);
    rd(`LIEG_ADDR_STATUS);
    chk(d[2:0], 3'b010);
    ex(OP_COPY, 0, 32, 0, 0);
    cm(32, 16'h0);
    sb(9, 1'b1);
    wm(4, 16'h1);
    wm(5, 16'h2);
    wm(6, 16'h3);
    ex(OP_WORD_SHIFT, 4, 6, 0, 0);
    cm(4, 16'h0);
    cm(6, 16'h2);
    ex(OP_WORD_SHIFT, 6, 4, 0, 0);
    sb(8, 1'b1);
    cm(5, 16'h1);
    $display("done words");
  endtask
  task automatic t_bits;
    ex(OP_LATCH, 0, 0, 0, 3'b001);
    ex(OP_LATCH, 0, 0, 0, 3'b000);
    sb(3, 1'b1);
    ex(OP_LATCH, 0, 0, 0, 3'b011);
    sb(3, 1'b0);
    ex(OP_RISE, 0, 0, 0, 3'b000);
    ex(OP_RISE, 0, 0, 0, 3'b001);
    sb(4, 1'b1);
    ex(OP_RISE, 0, 0, 0, 3'b001);
    sb(4, 1'b0);
    ex(OP_FALL, 0, 0, 0, 3'b001);
    ex(OP_FALL, 0, 0, 0, 3'b000);
    sb(5, 1'b1);
    ex(OP_FALL, 0, 0, 0, 3'b000);
    sb(5, 1'b0);
    wm(8, 16'h8000);
    ex(OP_BIT_SHIFT, 8, 9, 0, 3'b000);
    ex(OP_BIT_SHIFT, 8, 9, 0, 3'b011);
    ex(OP_BIT_SHIFT, 8, 9, 0, 3'b010);
    cm(8, 16'h0001);
    cm(9, 16'h0001);
    ex(OP_BIT_SHIFT, 8, 9, 0, 3'b100);
    cm(9, 16'h0);
    $display("done bits");
  endtask
  task automatic t_count;
    wr(`LIEG_ADDR_CNT_SV, 32'h3); // one counter and one timer, each number used once
    ex(OP_COUNTER, 0, 0, 0, 3'b001);
    ex(OP_COUNTER, 0, 0, 0, 3'b000);
    ex(OP_COUNTER, 0, 0, 0, 3'b001);
    ex(OP_COUNTER, 0, 0, 0, 3'b010);
    rd(`LIEG_ADDR_CNT_PV);
    chk(d, 32'h1);
    ex(OP_COUNTER, 0, 0, 0, 3'b100);
    ex(OP_COUNTER, 0, 0, 0, 3'b000);
    ex(OP_COUNTER, 0, 0, 0, 3'b010);
    rd(`LIEG_ADDR_CNT_PV);
    chk(d, 32'h3);
    sb(7, 1'b1);
    wr(`LIEG_ADDR_TIM_SV, 32'h3);
    ex(OP_TIMER, 0, 0, 0, 3'b000);
    rd(`LIEG_ADDR_TIM_PV);
    chk(d, 32'h3);
    repeat (20) ex(OP_TIMER, 0, 0, 0, 3'b001);
    rd(`LIEG_ADDR_TIM_PV);
    chk(d, 32'h0);
    sb(6, 1'b1);
    $display("done counter and timer");
  endtask
  // words 10..12 hold 7,0,0, control word in word 20
  task automatic t_rev;
    wm(10, 16'h0007);
    wm(20, 16'h0000);
    ex(OP_REV_SHIFT, 10, 12, 20, 0);
    cm(10, 16'h0007);
    wm(20, 16'h4000);
    ex(OP_REV_SHIFT, 10, 12, 20, 0);
    cm(11, 16'h0007);
    cm(10, 16'h0000);
    wm(20, 16'h6000);
    ex(OP_REV_SHIFT, 10, 12, 20, 0);
    cm(10, 16'h0007);
    wm(20, 16'h8000);
    ex(OP_REV_SHIFT, 10, 12, 20, 0);
    cm(10, 16'h0007);
    wm(20, 16'hc000);
    ex(OP_REV_SHIFT, 10, 12, 20, 0);
    cm(10, 16'h0000);
    $display("done reversible shift");
  endtask
  // positions 3 and 15 differ
  task automatic t_block;
    for (int i = 0; i < 16; i++)
    begin
      wm(32 + i, 16'(i));
      wm(48 + i, 16'(i) ^ ((i == 3 || i == 15) ? 16'h0100 : 16'h0));
    end
    wm(0, 16'hffff);
    ex(OP_BLOCK_CMP, 32, 48, 0, 0);
    cm(0, 16'h8008);
    $display("done block compare");
  endtask
  // setting 2 is eight cycles here
  task automatic t_scan;
    wr(`LIEG_ADDR_SCAN_MIN, 32'h0);
    scan(n, w);
    chk(n, 0);
    @(posedge clk);
    #1;
    chk(next_scan, 1'b0);
    wr(`LIEG_ADDR_SCAN_MIN, 32'h2);
    scan(n, w);
    scan(n, w);
    chk(w, 1'b1);
    chk(n >= 4 && n <= 9, 1'b1);
    $display("done scan pacing");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    bus = '0;
    scan_end = 1'b0;
    errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_words;
    t_bits;
    t_count;
    t_rev;
    t_block;
    t_scan;
    end_of_test;
  end
  // watchdog, the tests need far less than this
  initial
  begin
    #400000;
    errors++;
    end_of_test;
  end
endmodule // testbench
